// [src/serial_port_device.sv]
// serial port with control/status, format and data buffer registers
// Functional notes
// - full queue drops character, sets overrun bit 7
// - head byte parity mismatch sets bit 6
// - software clears parity error flag itself
// - bit 5 reads holding register empty
// - bit 4 gates new reception
// - queued bytes readable while receiver disabled
// - extra bit option sends bit 3
// - parity enabled sends generated parity instead
// - bit 2 loads extra bit or stop
// - received extra bit meaningless under parity
// - transmit done set at stop start
// - transmit done raises interrupt, software clears
// - receive available set at stop sample
// - receive available raises same interrupt
// - receive available holds while queue nonempty
// - register at 0x98, bit set/clear access
// - three-byte queue, stores with good stop
// - parity types odd, even, mark, space
// - multiprocessor mode needs extra bit one
// - data read pops oldest, advances next
`include "uart_cs_regs.svh"
module serial_port_device #(
  parameter int DIV = `SER_DIV_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  serial_link_if.device link,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic bit_set,
  input wire logic bit_clr,
  input wire logic [2:0] bit_sel,
  input wire logic irq_enable,
  output logic [7:0] rdata,
  output logic serial_irq
);

  // ***************************************************
  // state
  // ***************************************************
  uart_cs_pkg::dev_state_t s_q;
  uart_cs_pkg::dev_state_t s_d;
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_xbit;
  logic rx_stop;
  logic [7:0] cur;
  logic [7:0] wval;
  logic sw_we;
  logic pop;
  logic store;
  logic [1:0] cnt_pop;
  logic pe;
  logic xbe;
  logic mce;
  logic [1:0] pt;
  logic xsel;
  uart_cs_pkg::rxq_entry_t entry;

  localparam logic [15:0] RELOAD = 16'(DIV - 1);

  function automatic logic [7:0] ctrl_value(input uart_cs_pkg::dev_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[`CS_OVR] = s.ovr;
    v[`CS_PERR] = s.perr;
    v[`CS_THRE] = ~s.hold_full;
    v[`CS_REN] = s.ren;
    v[`CS_TBX] = s.tbx;
    v[`CS_RBX] = s.rbx;
    v[`CS_TI] = s.ti;
    v[`CS_RI] = s.ri;
    return v;
  endfunction

  // ***************************************************
  // next state
  // ***************************************************
  always_comb begin
    s_d = s_q;
    pe = s_q.fmt[`FMT_PE];
    xbe = s_q.fmt[`FMT_XBE];
    mce = s_q.fmt[`FMT_MCE];
    pt = s_q.fmt[`FMT_PT_HI:`FMT_PT_LO];
    cur = ctrl_value(s_q);
    s_d.rdata = 8'h00;

    // read port; data only in the cycle after the strobe
    pop = rd_en && (addr == `SFR_DATA_BUF) && (s_q.q_cnt != 2'h0);
    if (rd_en) begin
      if (addr == `SFR_CTRL_STATUS) begin
        s_d.rdata = cur;
      end else if (addr == `SFR_DATA_BUF) begin
        s_d.rdata = s_q.q[0].data;
      end else if (addr == `SFR_FORMAT) begin
        s_d.rdata = s_q.fmt;
      end
    end

    // receive queue; head sits in slot 0
    cnt_pop = s_q.q_cnt - {1'b0, pop};
    if (pop) begin
      for (int i = 0; i < `RXQ_DEPTH - 1; i++) begin
        s_d.q[i] = s_q.q[i+1];
      end
    end
    entry.data = rx_data;
    entry.xbit = xbe ? rx_xbit : rx_stop;
    entry.par_err = pe && (rx_xbit != uart_cs_pkg::parity_bit(rx_data, pt));
    store = rx_done && rx_stop && (cnt_pop != `RXQ_FULL);
    s_d.q_cnt = cnt_pop;
    if (store) begin
      s_d.q[cnt_pop] = entry;
      s_d.q_cnt = cnt_pop + 2'h1;
    end

    // software access; bit set/clear reaches only this register
    wval = cur;
    sw_we = 1'b0;
    if (wr_en && addr == `SFR_CTRL_STATUS) begin
      wval = wdata;
      sw_we = 1'b1;
    end
    if (bit_set) begin
      wval[bit_sel] = 1'b1;
      sw_we = 1'b1;
    end
    if (bit_clr) begin
      wval[bit_sel] = 1'b0;
      sw_we = 1'b1;
    end
    if (sw_we) begin
      s_d.ovr = wval[`CS_OVR];
      s_d.perr = wval[`CS_PERR];
      s_d.ren = wval[`CS_REN];
      s_d.tbx = wval[`CS_TBX];
      s_d.rbx = wval[`CS_RBX];
      s_d.ti = wval[`CS_TI];
      // a clear cannot drop the flag while bytes wait
      s_d.ri = wval[`CS_RI] | (s_q.ri & (s_d.q_cnt != 2'h0));
    end
    if (wr_en && addr == `SFR_FORMAT) begin
      s_d.fmt = wdata;
    end
    // writes into an occupied holding register are dropped
    if (wr_en && addr == `SFR_DATA_BUF && !s_q.hold_full) begin
      s_d.hold = wdata;
      s_d.hold_full = 1'b1;
    end

    // hardware events win over a software write in the same cycle
    if (rx_done && (cnt_pop == `RXQ_FULL)) begin
      s_d.ovr = 1'b1;
    end
    if (store && (!mce || rx_xbit)) begin
      s_d.ri = 1'b1;
    end
    if ((pop && s_q.q_cnt > 2'h1) || (store && cnt_pop == 2'h0)) begin
      s_d.rbx = s_d.q[0].xbit;
      if (pe && s_d.q[0].par_err) begin
        s_d.perr = 1'b1;
      end
    end

    // transmitter
    xsel = pe ? uart_cs_pkg::parity_bit(s_q.hold, pt) : s_q.tbx;
    if (s_q.tx.st == uart_cs_pkg::FR_IDLE && s_q.hold_full) begin
      s_d.tx = uart_cs_pkg::tx_start(s_q.hold, xsel, xbe | pe, RELOAD);
      s_d.hold_full = 1'b0;
    end else begin
      s_d.tx = uart_cs_pkg::tx_next(s_q.tx, RELOAD);
    end
    if (s_q.tx.st != uart_cs_pkg::FR_STOP && s_d.tx.st == uart_cs_pkg::FR_STOP) begin
      s_d.ti = 1'b1;
    end
  end

  // ***************************************************
  // registers
  // ***************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{tx: '{st: uart_cs_pkg::FR_IDLE, cnt: 16'h0000, idx: 3'h0, shift: 8'h00,
                     xbit: 1'b0, has_extra: 1'b0, txd: 1'b1},
               hold: 8'h00,
               hold_full: 1'b0,
               fmt: `FMT_RESET,
               ovr: 1'b0,
               perr: 1'b0,
               ren: 1'b0,
               tbx: 1'b0,
               rbx: 1'b0,
               ti: 1'b0,
               ri: 1'b0,
               q: '0,
               q_cnt: 2'h0,
               rdata: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign rdata = s_q.rdata;
  // one shared request for both directions
  assign serial_irq = irq_enable & (s_q.ti | s_q.ri);
  assign link.dev_txd = s_q.tx.txd;

  // receiver starts no new frame while disabled; queue reads stay open
  frame_receiver #(.DIV(DIV)) u_rx (
    .mclk(mclk),
    .rstn(rstn),
    .line(link.node_txd),
    .enable(s_q.ren),
    .extra_en(xbe | pe),
    .done(rx_done),
    .data(rx_data),
    .xbit(rx_xbit),
    .stop(rx_stop)
  );

endmodule

// [src/uart_cs_regs.svh]
// register addresses, field positions, reset values and timing of the serial port
`ifndef UART_CS_REGS_SVH
`define UART_CS_REGS_SVH

// ***************************************************
// register addresses
// ***************************************************
`define SFR_CTRL_STATUS 8'h98
`define SFR_DATA_BUF 8'h99
`define SFR_FORMAT 8'hA9

// ***************************************************
// control and status fields
// ***************************************************
`define CS_OVR 3'h7
`define CS_PERR 3'h6
`define CS_THRE 3'h5
`define CS_REN 3'h4
`define CS_TBX 3'h3
`define CS_RBX 3'h2
`define CS_TI 3'h1
`define CS_RI 3'h0
`define CS_RESET 8'h20

// ***************************************************
// format fields
// ***************************************************
`define FMT_MCE 3'h7
`define FMT_PT_HI 3'h6
`define FMT_PT_LO 3'h5
`define FMT_PE 3'h4
`define FMT_XBE 3'h1
`define FMT_RESET 8'h0C

// ***************************************************
// parity types
// ***************************************************
`define PT_ODD 2'h0
`define PT_EVEN 2'h1
`define PT_MARK 2'h2
`define PT_SPACE 2'h3

// ***************************************************
// queue and frame
// ***************************************************
`define RXQ_DEPTH 3
`define RXQ_FULL 2'h3
`define SER_LAST_BIT 3'h7

// ***************************************************
// timing
// ***************************************************
`define SER_BIT_TIME_NS 1000
`define SER_MCLK_PERIOD_NS 100
`define SER_DIV_CYCLES ((`SER_BIT_TIME_NS) / (`SER_MCLK_PERIOD_NS))

`endif

// [src/uart_cs_pkg.sv]
// types and shared frame helpers of the serial port blocks
`include "uart_cs_regs.svh"

package uart_cs_pkg;

  typedef enum logic [2:0] {
    FR_IDLE = 3'h0,
    FR_START = 3'h1,
    FR_DATA = 3'h3,
    FR_EXTRA = 3'h7,
    FR_STOP = 3'h2
  } frame_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic xbit;
    logic par_err;
  } rxq_entry_t;

  typedef struct packed {
    frame_state_t st;
    logic [15:0] cnt;
    logic [2:0] idx;
    logic [7:0] shift;
    logic xbit;
    logic has_extra;
    logic txd;
  } tx_state_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    frame_state_t st;
    logic [15:0] cnt;
    logic [2:0] idx;
    logic [7:0] shift;
    logic xbit;
    logic stop;
    logic done;
  } rx_state_t;

  typedef struct packed {
    tx_state_t tx;
    logic [7:0] hold;
    logic hold_full;
    logic [7:0] fmt;
    logic ovr;
    logic perr;
    logic ren;
    logic tbx;
    logic rbx;
    logic ti;
    logic ri;
    rxq_entry_t [`RXQ_DEPTH-1:0] q;
    logic [1:0] q_cnt;
    logic [7:0] rdata;
  } dev_state_t;

  typedef struct packed {
    tx_state_t tx;
  } node_state_t;

  function automatic logic parity_bit(input logic [7:0] d, input logic [1:0] pt);
    logic p;
    p = 1'b0;
    unique case (pt)
      `PT_ODD: p = ~(^d);
      `PT_EVEN: p = ^d;
      `PT_MARK: p = 1'b1;
      `PT_SPACE: p = 1'b0;
    endcase
    return p;
  endfunction

  function automatic tx_state_t tx_start(input logic [7:0] d, input logic x,
                                          input logic ext, input logic [15:0] reload);
    tx_state_t n;
    n.st = FR_START;
    n.cnt = reload;
    n.idx = 3'h0;
    n.shift = d;
    n.xbit = x;
    n.has_extra = ext;
    n.txd = 1'b0;
    return n;
  endfunction

  // one step of the transmit serialiser; reload is bit time minus one
  function automatic tx_state_t tx_next(input tx_state_t s, input logic [15:0] reload);
    tx_state_t n;
    n = s;
    if (s.st != FR_IDLE) begin
      if (s.cnt != 16'h0000) begin
        n.cnt = s.cnt - 16'h0001;
      end else begin
        n.cnt = reload;
        unique case (s.st)
          FR_START: begin
            n.st = FR_DATA;
            n.txd = s.shift[0];
          end
          FR_DATA: begin
            if (s.idx == `SER_LAST_BIT) begin
              n.st = s.has_extra ? FR_EXTRA : FR_STOP;
              n.txd = s.has_extra ? s.xbit : 1'b1;
            end else begin
              n.idx = s.idx + 3'h1;
              n.shift = s.shift >> 1;
              n.txd = s.shift[1];
            end
          end
          FR_EXTRA: begin
            n.st = FR_STOP;
            n.txd = 1'b1;
          end
          FR_STOP: begin
            n.st = FR_IDLE;
            n.txd = 1'b1;
          end
          default: begin
            n.st = FR_IDLE;
            n.txd = 1'b1;
          end
        endcase
      end
    end
    return n;
  endfunction

endpackage

// [src/serial_link_if.sv]
// serial line between the port and the far node
interface serial_link_if;
  logic dev_txd;
  logic node_txd;
  modport device (output dev_txd, input node_txd);
  modport node (input dev_txd, output node_txd);
endinterface

// [src/frame_receiver.sv]
// serial frame receiver with pin synchroniser, shared by both ends
`include "uart_cs_regs.svh"
module frame_receiver #(
  parameter int DIV = `SER_DIV_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic line,
  input wire logic enable,
  input wire logic extra_en,
  output logic done,
  output logic [7:0] data,
  output logic xbit,
  output logic stop
);

  uart_cs_pkg::rx_state_t s_q;
  uart_cs_pkg::rx_state_t s_d;

  localparam logic [15:0] RELOAD = 16'(DIV - 1);
  localparam logic [15:0] HALF = 16'(DIV / 2 - 1);

  always_comb begin
    s_d = s_q;
    s_d.sync1 = line;
    s_d.sync2 = s_q.sync1;
    s_d.done = 1'b0;
    if (s_q.st != uart_cs_pkg::FR_IDLE && s_q.cnt != 16'h0000) begin
      s_d.cnt = s_q.cnt - 16'h0001;
    end else begin
      s_d.cnt = RELOAD;
      unique case (s_q.st)
        uart_cs_pkg::FR_IDLE: begin
          // new starts only while enabled; a frame under way always completes
          if (enable && !s_q.sync2) begin
            s_d.st = uart_cs_pkg::FR_START;
            s_d.cnt = HALF;
          end
        end
        uart_cs_pkg::FR_START: begin
          // glitch shorter than half a bit returns to idle
          s_d.st = s_q.sync2 ? uart_cs_pkg::FR_IDLE : uart_cs_pkg::FR_DATA;
          s_d.idx = 3'h0;
        end
        uart_cs_pkg::FR_DATA: begin
          s_d.shift = {s_q.sync2, s_q.shift[7:1]};
          s_d.idx = s_q.idx + 3'h1;
          if (s_q.idx == `SER_LAST_BIT) begin
            s_d.st = extra_en ? uart_cs_pkg::FR_EXTRA : uart_cs_pkg::FR_STOP;
          end
        end
        uart_cs_pkg::FR_EXTRA: begin
          s_d.xbit = s_q.sync2;
          s_d.st = uart_cs_pkg::FR_STOP;
        end
        uart_cs_pkg::FR_STOP: begin
          s_d.stop = s_q.sync2;
          s_d.done = 1'b1;
          s_d.st = uart_cs_pkg::FR_IDLE;
        end
        default: s_d.st = uart_cs_pkg::FR_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{sync1: 1'b1, sync2: 1'b1, st: uart_cs_pkg::FR_IDLE, cnt: 16'h0000,
               idx: 3'h0, shift: 8'h00, xbit: 1'b0, stop: 1'b0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
  assign data = s_q.shift;
  assign xbit = s_q.xbit;
  assign stop = s_q.stop;

endmodule

// [src/serial_node.sv]
// far serial node: plain byte stream user port on one side, the line on the other
`include "uart_cs_regs.svh"
module serial_node #(
  parameter int DIV = `SER_DIV_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  serial_link_if.node link,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_extra,
  input wire logic extra_en,
  input wire logic parity_en,
  input wire logic [1:0] parity_type,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_extra,
  output logic rx_stop_ok
);

  uart_cs_pkg::node_state_t s_q;
  uart_cs_pkg::node_state_t s_d;
  logic xsel;

  localparam logic [15:0] RELOAD = 16'(DIV - 1);

  assign tx_ready = (s_q.tx.st == uart_cs_pkg::FR_IDLE);

  always_comb begin
    s_d = s_q;
    xsel = parity_en ? uart_cs_pkg::parity_bit(tx_data, parity_type) : tx_extra;
    if (tx_valid && tx_ready) begin
      s_d.tx = uart_cs_pkg::tx_start(tx_data, xsel, extra_en | parity_en, RELOAD);
    end else begin
      s_d.tx = uart_cs_pkg::tx_next(s_q.tx, RELOAD);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{tx: '{st: uart_cs_pkg::FR_IDLE, cnt: 16'h0000, idx: 3'h0, shift: 8'h00,
                     xbit: 1'b0, has_extra: 1'b0, txd: 1'b1}};
    end else begin
      s_q <= s_d;
    end
  end

  assign link.node_txd = s_q.tx.txd;

  frame_receiver #(.DIV(DIV)) u_rx (
    .mclk(mclk),
    .rstn(rstn),
    .line(link.dev_txd),
    .enable(1'b1),
    .extra_en(extra_en | parity_en),
    .done(rx_valid),
    .data(rx_data),
    .xbit(rx_extra),
    .stop(rx_stop_ok)
  );

endmodule

// [verif/uart_cs_assertions.sv]
// line and register port checks for the serial port pair
module uart_cs_assertions #(
  parameter int DIV = 10
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic dev_txd,
  input wire logic node_txd,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic bit_clr,
  input wire logic irq_enable,
  input wire logic [7:0] rdata,
  input wire logic serial_irq
);
  // ****
  // device frame position
  // ****
  // saturates when idle; a new start is only accepted after a full frame
  localparam logic [7:0] IDLE = 8'(12 * DIV);
  typedef struct packed {
    logic [7:0] pos;
    logic prev;
  } mon_t;
  mon_t mon_q;
  mon_t mon_d;
  always_comb begin
    mon_d = mon_q;
    mon_d.prev = dev_txd;
    if (!dev_txd && mon_q.prev && mon_q.pos >= 8'(10 * DIV)) begin
      mon_d.pos = 8'h01;
    end else if (mon_q.pos < IDLE) begin
      mon_d.pos = mon_q.pos + 8'h01;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mon_q <= '{pos: IDLE, prev: 1'h1};
    end else begin
      mon_q <= mon_d;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_load;
    wr_en && addr == 8'h99 && mon_q.pos == IDLE && dev_txd;
  endsequence
  property p_reset_idle;
    $rose(rstn) |-> dev_txd && node_txd;
  endproperty
  property p_rdata_idle;
    !$past(rd_en) |-> rdata == 8'h00;
  endproperty
  property p_unmapped;
    rd_en && !(addr inside {8'h98, 8'h99, 8'hA9}) |=> rdata == 8'h00;
  endproperty
  property p_irq_gate;
    !irq_enable |-> !serial_irq;
  endproperty
  // flags are never dropped by hardware, only by a register access
  property p_irq_hold;
    $fell(serial_irq) && $stable(irq_enable) |-> $past(wr_en) || $past(bit_clr);
  endproperty
  property p_start_low;
    mon_q.pos < 8'(DIV) |-> !dev_txd;
  endproperty
  property p_bit_stable;
    mon_q.pos < 8'(9 * DIV) && mon_q.pos % 8'(DIV) != 8'h00 |-> $stable(dev_txd);
  endproperty
  property p_tx_start;
    s_load |-> ##[1:4] !dev_txd;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("line not idle after reset");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled");
  a_irq_hold: assert property (p_irq_hold) else $error("flag dropped by hardware");
  a_start_low: assert property (p_start_low) else $error("start bit too short");
  a_bit_stable: assert property (p_bit_stable) else $error("bit changed mid bit");
  a_tx_start: assert property (p_tx_start) else $error("write did not start frame");
endmodule

// [verif/tb_top.sv]
// self-checking bench joining the serial port and the far node
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 4;
  logic mclk, rstn, wr_en, rd_en, bit_set, bit_clr, irq_enable, serial_irq, rd_seen;
  logic [7:0] addr, wdata, rdata, tx_data, rx_data, d;
  logic [2:0] bit_sel;
  logic tx_valid, tx_extra, extra_en, parity_en, tx_ready, rx_valid, rx_extra, rx_stop_ok;
  logic [1:0] parity_type;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [15:0] rq[$];
  logic [9:0] nq[$];
  logic [7:0] b[4];
  serial_link_if link ();
  serial_port_device #(.DIV(DIV)) serial_port_device_i (.mclk(mclk), .rstn(rstn),
    .link(link.device), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .bit_set(bit_set), .bit_clr(bit_clr), .bit_sel(bit_sel), .irq_enable(irq_enable),
    .rdata(rdata), .serial_irq(serial_irq));
  serial_node #(.DIV(DIV)) serial_node_i (.mclk(mclk), .rstn(rstn), .link(link.node),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_extra(tx_extra), .extra_en(extra_en),
    .parity_en(parity_en), .parity_type(parity_type), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_extra(rx_extra), .rx_stop_ok(rx_stop_ok));
  uart_cs_assertions #(.DIV(DIV)) uart_cs_assertions_i (.mclk(mclk), .rstn(rstn),
    .dev_txd(link.dev_txd), .node_txd(link.node_txd), .addr(addr), .wr_en(wr_en),
    .rd_en(rd_en), .bit_clr(bit_clr), .irq_enable(irq_enable), .rdata(rdata),
    .serial_irq(serial_irq));
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  // ****
  // tasks
  // ****
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  function automatic logic par(input logic [7:0] v, input logic [1:0] t);
    case (t)
      2'h0: return ~^v;
      2'h1: return ^v;
      2'h2: return 1'h1;
      default: return 1'h0;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'h1;
    @(posedge mclk);
    wr_en <= 1'h0;
  endtask
  // only the masked bits are compared; the rest may legally vary
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'h1;
    rq.push_back({m, e & m});
    @(posedge mclk);
    rd_en <= 1'h0;
  endtask
  task automatic bop(input logic s, input logic [2:0] n);
    @(posedge mclk);
    bit_set <= s;
    bit_clr <= !s;
    bit_sel <= n;
    @(posedge mclk);
    bit_set <= 1'h0;
    bit_clr <= 1'h0;
  endtask
  task automatic send(input logic [7:0] v, input logic x);
    int k;
    k = 0;
    @(posedge mclk);
    tx_valid <= 1'h1;
    tx_data <= v;
    tx_extra <= x;
    do @(posedge mclk); while (!tx_ready && ++k < 50);
    tx_valid <= 1'h0;
    do @(posedge mclk); while (!tx_ready && ++k < 100);
    if (!tx_ready) n_mismatch++;
    repeat (DIV) @(posedge mclk);
  endtask
  task automatic wait_nq();
    int k;
    k = 0;
    while (nq.size() != 0 && k < 200) begin
      @(posedge mclk);
      k++;
    end
    // a frame that never arrived counts against the run
    if (nq.size() != 0) n_mismatch++;
    repeat (2 * DIV) @(posedge mclk);
  endtask
  // ****
  // result watcher and timeout
  // ****
  always @(posedge mclk) begin
    cyc++;
    if (rd_seen && rq.size() > 0) begin
      `CHK("rdata", rq[0][7:0], rdata & rq[0][15:8])
      rq.delete(0);
    end
    rd_seen <= rd_en;
    if (rx_valid) begin
      `CHK("node rx", nq[0], {nq[0][9], rx_extra & nq[0][9], rx_data})
      `CHK("node stop", 1'h1, rx_stop_ok)
      nq.delete(0);
    end
    if (cyc == 8000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    {rstn, wr_en, rd_en, bit_set, bit_clr, irq_enable} = 6'h00;
    {addr, wdata, tx_data, bit_sel, parity_type} = 29'h0;
    {tx_valid, tx_extra, extra_en, parity_en} = 4'h0;
    void'($urandom(32'h4d63e175));
    repeat (3) @(posedge mclk);
    rstn <= 1'h1;
    rd(8'h98, 8'h20, 8'hFF);
    rd(8'hA9, 8'h0C, 8'hFF);
    rd(8'h55, 8'h00, 8'hFF);
    wr(8'h98, 8'h00);
    rd(8'h98, 8'h20, 8'hFF);
    bop(1'h1, 3'h4);
    rd(8'h98, 8'h30, 8'hFF);
    done("registers");
    irq_enable <= 1'h1;
    d = 8'($urandom);
    nq.push_back({2'h0, d});
    wr(8'h99, d);
    wait_nq();
    rd(8'h98, 8'h32, 8'hFB);
    @(negedge mclk);
    `CHK("irq", 1'h1, serial_irq)
    bop(1'h0, 3'h1);
    @(negedge mclk);
    `CHK("irq", 1'h0, serial_irq)
    done("transmit");
    bop(1'h1, 3'h3);
    extra_en <= 1'h1;
    wr(8'hA9, 8'h02);
    d = 8'($urandom);
    nq.push_back({2'h3, d});
    wr(8'h99, d);
    wait_nq();
    parity_en <= 1'h1;
    // extra bit is held at one, so space parity shows it being overridden
    for (int p = 0; p < 4; p++) begin
      parity_type <= 2'(p);
      wr(8'hA9, 8'h10 | 8'(p << 5));
      d = 8'($urandom);
      nq.push_back({1'h1, par(d, 2'(p)), d});
      wr(8'h99, d);
      wait_nq();
    end
    bop(1'h0, 3'h1);
    done("extra and parity");
    extra_en <= 1'h0;
    parity_en <= 1'h0;
    wr(8'hA9, 8'h00);
    for (int i = 0; i < 4; i++) begin
      b[i] = 8'($urandom);
      send(b[i], 1'h0);
    end
    rd(8'h98, 8'hBD, 8'hFF);
    bop(1'h0, 3'h4);
    bop(1'h0, 3'h0);
    rd(8'h98, 8'h01, 8'h01);
    for (int i = 0; i < 3; i++) begin
      rd(8'h99, b[i], 8'hFF);
    end
    bop(1'h0, 3'h0);
    rd(8'h98, 8'h00, 8'h01);
    send(8'($urandom), 1'h0);
    rd(8'h98, 8'h00, 8'h01);
    done("receive queue");
    wr(8'h98, 8'h10);
    wr(8'hA9, 8'h30);
    parity_en <= 1'h1;
    parity_type <= 2'h0;
    d = 8'($urandom);
    send(d, 1'h0);
    rd(8'h98, 8'h41, 8'hC1);
    rd(8'h99, d, 8'hFF);
    // receive flag stays up after the pop until software clears it
    rd(8'h98, 8'h41, 8'h41);
    wr(8'h98, 8'h10);
    rd(8'h98, 8'h00, 8'h40);
    done("parity error");
    parity_en <= 1'h0;
    extra_en <= 1'h1;
    wr(8'hA9, 8'h82);
    send(8'($urandom), 1'h0);
    rd(8'h98, 8'h00, 8'h01);
    send(8'($urandom), 1'h1);
    rd(8'h98, 8'h01, 8'h05);
    repeat (2) @(posedge mclk);
    done("multiprocessor");
    finish_test();
  end
endmodule
